// ---- core/cs_decode.sv ----
/*
 * Chip-select address decoder: four areas, each with a start register,
 * a compare mask and a control register, plus default-area settings.
 * Assumes the CPU bus address and cycle strobe come from logic on clk_i,
 * and that software reaches the registers over a 32-bit classic Wishbone bus.
 */
// Overview of operation
// - area 2 full-space mode covers 000080H to FFFFFFH
// - mode bit set: area 2 uses own registers
// - reset clears the area 2 mode bit
// - compare unmasked address bits against start value
// - hit drives select low only when enabled
// - several hits: smallest area number wins
// - internal I/O range suppresses every chip select
// - start register holds address bits 23 to 16
// - start bits below 16 compare as zero
// - mask zero compares the bit, one ignores
// - maskable bits 8-20, 8-21, 15-22 per area
// - one mask bit covers bits 14-9 / 15-9
// - bits above maskable range always compared
// - reset sets start/mask to ones, clears enables except area 2
// - after reset only area 2 enabled, full space
// - control bit 4 is the area enable
// - unmatched accesses use the default-area settings
`timescale 1ns/1ns
`default_nettype none

module cs_decode
    import cs_decode_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // register bus
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [10:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // cpu bus
    input  wire logic        cpu_cycle_i,
    input  wire logic [23:0] cpu_addr_i,
    // external selects and cycle attributes
    output logic             chip_select_0_n_o,
    output logic             chip_select_1_n_o,
    output logic             chip_select_2_n_o,
    output logic             chip_select_3_n_o,
    output logic             internal_io_o,
    output cycle_attr_s      cycle_attr_o
);

    ////////////////////////////////////////////////////////////////////////////
    // functions

    // compare-enable vector over address bits 23..8 for one area
    function automatic logic [15:0] care_bits(input logic [1:0] area, input logic [7:0] mask);
        logic [15:0] c;
        c = 16'h0000;
        case (area)
            2'd0:
            begin
                c[15:13] = 3'h7;
                c[12:7]  = ~mask[7:2];
                c[6:1]   = {6{~mask[1]}};
                c[0]     = ~mask[0];
            end
            2'd1:
            begin
                c[15:14] = 2'h3;
                c[13:8]  = ~mask[7:2];
                c[7:1]   = {7{~mask[1]}};
                c[0]     = ~mask[0];
            end
            default:
            begin
                c[15]    = 1'b1;
                c[14:7]  = ~mask;
                c[6:0]   = 7'h00;
            end
        endcase
        return c;
    endfunction

    // start value sits on bits 23..16, the bits below compare as zero
    function automatic logic area_match(input logic [23:0] addr, input logic [7:0] start,
                                        input logic [15:0] care);
        logic [15:0] expect_v;
        expect_v = {start, 8'h00};
        return ((addr[23:8] ^ expect_v) & care) == 16'h0000;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register storage

    logic [7:0]                start_q [NUM_AREAS];
    logic [7:0]                mask_q  [NUM_AREAS];
    logic [CTRL_WIDTH-1:0]     ctrl_q  [NUM_AREAS];
    logic [DEF_CTRL_WIDTH-1:0] def_ctrl_q;

    logic       bus_req;
    logic       wr_req;
    logic [8:0] reg_idx;

    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_req  = bus_req & wb_we_i & wb_sel_i[0];
    assign reg_idx = wb_adr_i[10:2];

    // start registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < NUM_AREAS; i++)
            begin
                start_q[i] <= START_RESET;
            end
        end
        else if (wr_req)
        begin
            case (reg_idx)
                IDX_AREA0_START: start_q[0] <= wb_dat_i[7:0];
                IDX_AREA1_START: start_q[1] <= wb_dat_i[7:0];
                IDX_AREA2_START: start_q[2] <= wb_dat_i[7:0];
                IDX_AREA3_START: start_q[3] <= wb_dat_i[7:0];
                default:
                begin
                end
            endcase
        end
    end

    // compare masks
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < NUM_AREAS; i++)
            begin
                mask_q[i] <= MASK_RESET;
            end
        end
        else if (wr_req)
        begin
            case (reg_idx)
                IDX_AREA0_MASK: mask_q[0] <= wb_dat_i[7:0];
                IDX_AREA1_MASK: mask_q[1] <= wb_dat_i[7:0];
                IDX_AREA2_MASK: mask_q[2] <= wb_dat_i[7:0];
                IDX_AREA3_MASK: mask_q[3] <= wb_dat_i[7:0];
                default:
                begin
                end
            endcase
        end
    end

    // control registers: enable, mode, bus width, wait
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_q[0]  <= CTRL_RESET;
            ctrl_q[1]  <= CTRL_RESET;
            ctrl_q[2]  <= AREA2_CTRL_RESET;
            ctrl_q[3]  <= CTRL_RESET;
        end
        else if (wr_req)
        begin
            case (reg_idx)
                IDX_AREA0_CTRL:   ctrl_q[0]  <= wb_dat_i[CTRL_WIDTH-1:0];
                IDX_AREA1_CTRL:   ctrl_q[1]  <= wb_dat_i[CTRL_WIDTH-1:0];
                IDX_AREA2_CTRL:   ctrl_q[2]  <= wb_dat_i[CTRL_WIDTH-1:0];
                IDX_AREA3_CTRL:   ctrl_q[3]  <= wb_dat_i[CTRL_WIDTH-1:0];
                default:
                begin
                end
            endcase
        end
    end

    // default-area settings apply whenever no enabled area hits
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            def_ctrl_q <= DEF_CTRL_RESET;
        end
        else if (wr_req && (reg_idx == IDX_DEFAULT_CTRL))
        begin
            def_ctrl_q <= wb_dat_i[DEF_CTRL_WIDTH-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register bus answer: one wait state, unmapped reads give zero

    logic [7:0] rd_val;

    always_comb
    begin
        rd_val = 8'h00;
        case (reg_idx)
            IDX_AREA0_START:  rd_val = start_q[0];
            IDX_AREA0_MASK:   rd_val = mask_q[0];
            IDX_AREA1_START:  rd_val = start_q[1];
            IDX_AREA1_MASK:   rd_val = mask_q[1];
            IDX_AREA2_START:  rd_val = start_q[2];
            IDX_AREA2_MASK:   rd_val = mask_q[2];
            IDX_AREA3_START:  rd_val = start_q[3];
            IDX_AREA3_MASK:   rd_val = mask_q[3];
            IDX_AREA0_CTRL:   rd_val = {3'h0, ctrl_q[0]};
            IDX_AREA1_CTRL:   rd_val = {3'h0, ctrl_q[1]};
            IDX_AREA2_CTRL:   rd_val = {3'h0, ctrl_q[2]};
            IDX_AREA3_CTRL:   rd_val = {3'h0, ctrl_q[3]};
            IDX_DEFAULT_CTRL: rd_val = {5'h00, def_ctrl_q};
            default:          rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= bus_req;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_dat_o <= 32'h0000_0000;
        end
        else if (bus_req & ~wb_we_i)
        begin
            wb_dat_o <= {24'h00_0000, rd_val};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    logic [NUM_AREAS-1:0] area_hit;
    logic [NUM_AREAS-1:0] area_en;
    logic                 full_space_hit;
    logic                 area2_full_space_select;
    logic                 in_int_io;

    // mode bit zero means area 2 spans the whole external space
    assign area2_full_space_select = ~ctrl_q[2][CTRL_MODE_BIT];
    assign full_space_hit = (cpu_addr_i >= FULL_SPACE_FIRST)
                          & (cpu_addr_i <= FULL_SPACE_LAST);
    assign in_int_io = cpu_addr_i <= INT_IO_LAST;

    always_comb
    begin
        for (int i = 0; i < NUM_AREAS; i++)
        begin
            area_en[i]  = ctrl_q[i][CTRL_ENABLE_BIT];
            area_hit[i] = area_match(cpu_addr_i, start_q[i], care_bits(2'(i), mask_q[i]));
        end
        if (area2_full_space_select)
        begin
            area_hit[2] = full_space_hit;
        end
        // otherwise area 2 keeps its register match
    end

    logic [NUM_AREAS-1:0] sel_onehot;
    cycle_attr_s          sel_attr;

    always_comb
    begin
        sel_onehot = '0;
        sel_attr   = '{bus_8bit: def_ctrl_q[CTRL_BUS_BIT],
                       wait_mode: def_ctrl_q[CTRL_WAIT_LSB +: 2]};
        if (!in_int_io)
        begin
            for (int i = NUM_AREAS - 1; i >= 0; i--)
            begin
                if (area_hit[i] && area_en[i])
                begin
                    // lowest number is checked last, so it wins
                    sel_onehot        = '0;
                    sel_onehot[i]     = 1'b1;
                    sel_attr.bus_8bit  = ctrl_q[i][CTRL_BUS_BIT];
                    sel_attr.wait_mode = ctrl_q[i][CTRL_WAIT_LSB +: 2];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs; idle or unselected selects read high

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            chip_select_0_n_o <= 1'b1;
        end
        else
        begin
            chip_select_0_n_o <= ~(cpu_cycle_i & sel_onehot[0]);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            chip_select_1_n_o <= 1'b1;
        end
        else
        begin
            chip_select_1_n_o <= ~(cpu_cycle_i & sel_onehot[1]);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            chip_select_2_n_o <= 1'b1;
        end
        else
        begin
            chip_select_2_n_o <= ~(cpu_cycle_i & sel_onehot[2]);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            chip_select_3_n_o <= 1'b1;
        end
        else
        begin
            chip_select_3_n_o <= ~(cpu_cycle_i & sel_onehot[3]);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            internal_io_o <= 1'b0;
        end
        else
        begin
            internal_io_o <= cpu_cycle_i & in_int_io;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cycle_attr_o <= CYCLE_ATTR_RESET;
        end
        else if (cpu_cycle_i)
        begin
            cycle_attr_o <= sel_attr;
        end
    end

endmodule

`default_nettype wire

// ---- core/cs_decode_pkg.sv ----
/*
 * Constants and carrier types for the chip-select address decoder:
 * register indices, field positions, reset values and the address ranges.
 * Assumes a 24-bit CPU address and a 32-bit classic Wishbone register bus.
 */
package cs_decode_pkg;

    // register indices; the byte address on the bus is four times the index
    localparam logic [8:0] IDX_AREA0_START   = 9'h03c;
    localparam logic [8:0] IDX_AREA0_MASK    = 9'h03d;
    localparam logic [8:0] IDX_AREA1_START   = 9'h03e;
    localparam logic [8:0] IDX_AREA1_MASK    = 9'h03f;
    localparam logic [8:0] IDX_AREA2_START   = 9'h05c;
    localparam logic [8:0] IDX_AREA2_MASK    = 9'h05d;
    localparam logic [8:0] IDX_AREA3_START   = 9'h05e;
    localparam logic [8:0] IDX_AREA3_MASK    = 9'h05f;
    localparam logic [8:0] IDX_AREA0_CTRL    = 9'h068;
    localparam logic [8:0] IDX_AREA1_CTRL    = 9'h069;
    localparam logic [8:0] IDX_AREA2_CTRL    = 9'h06a;
    localparam logic [8:0] IDX_AREA3_CTRL    = 9'h06b;
    localparam logic [8:0] IDX_DEFAULT_CTRL  = 9'h06c;

    // area control register fields
    localparam int CTRL_WAIT_LSB   = 0;
    localparam int CTRL_BUS_BIT    = 2;
    localparam int CTRL_MODE_BIT   = 3;
    localparam int CTRL_ENABLE_BIT = 4;
    localparam int CTRL_WIDTH      = 5;
    localparam int DEF_CTRL_WIDTH  = 3;

    // reset values
    localparam logic [7:0]                START_RESET    = 8'hff;
    localparam logic [7:0]                MASK_RESET     = 8'hff;
    localparam logic [CTRL_WIDTH-1:0]     CTRL_RESET     = 5'h00;
    localparam logic [CTRL_WIDTH-1:0]     AREA2_CTRL_RESET = 5'h10;
    localparam logic [DEF_CTRL_WIDTH-1:0] DEF_CTRL_RESET = 3'h0;

    // address space
    localparam int         NUM_AREAS        = 4;
    localparam logic [23:0] INT_IO_LAST     = 24'h00007f;
    localparam logic [23:0] FULL_SPACE_FIRST = 24'h000080;
    localparam logic [23:0] FULL_SPACE_LAST  = 24'hffffff;

    // attributes that go with the current external bus cycle
    typedef struct packed {
        logic       bus_8bit;
        logic [1:0] wait_mode;
    } cycle_attr_s;

    localparam cycle_attr_s CYCLE_ATTR_RESET = '{bus_8bit: 1'b0, wait_mode: 2'h0};

endpackage

// ---- dv/cs_decode_chk.sv ----
/* checker for the chip-select decoder, watching its top-level ports only.
   assumes one clock clk_i and a synchronous active-high rst_i. */
`timescale 1ns/1ns
`default_nettype none
module cs_decode_chk
    import cs_decode_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [10:0] wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic        cpu_cycle_i,
    input wire logic [23:0] cpu_addr_i,
    input wire logic        chip_select_0_n_o,
    input wire logic        chip_select_1_n_o,
    input wire logic        chip_select_2_n_o,
    input wire logic        chip_select_3_n_o,
    input wire logic        internal_io_o,
    input wire cycle_attr_s cycle_attr_o
);
////////////////////////////////////////////////////////////////
    // shadow of the control registers at indices 68..6f
    logic [4:0] ctl_q [8];
    logic [3:0] cs_n;
    logic [3:0] en_live;
    logic [2:0] def_attr;
    logic       io_hit;
    assign cs_n = {chip_select_3_n_o, chip_select_2_n_o, chip_select_1_n_o, chip_select_0_n_o};
    assign io_hit = cpu_cycle_i && (cpu_addr_i <= INT_IO_LAST);
    assign def_attr = ctl_q[4][2:0];
    always_comb
    begin
        for (int k = 0; k < 4; k++)
            en_live[k] = cpu_cycle_i && ctl_q[k][CTRL_ENABLE_BIT];
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            for (int i = 0; i < 8; i++)
                ctl_q[i] <= (i == 2) ? AREA2_CTRL_RESET : CTRL_RESET;
        else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o && wb_adr_i[10:5] == 6'h0d)
            ctl_q[wb_adr_i[4:2]] <= wb_dat_i[4:0];
    end
////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    sequence s_all_idle;
        cs_n == 4'hf;
    endsequence
    a_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> s_ack_pulse)
        else $error("ack was not a single pulse");
    a_idle_high: assert property (!cpu_cycle_i |=> s_all_idle)
        else $error("select low outside a bus cycle");
    a_single_select: assert property ($countones(~cs_n) <= 1)
        else $error("more than one select low");
    a_io_quiet: assert property (io_hit |=> (cs_n == 4'hf) && internal_io_o)
        else $error("internal io cycle drove a select");
    a_io_attr: assert property (io_hit |=> cycle_attr_o == $past(def_attr))
        else $error("default attributes not used");
    a_gate_area0: assert property (!chip_select_0_n_o |-> $past(en_live[0]))
        else $error("area 0 selected while disabled");
    a_gate_area3: assert property (!chip_select_3_n_o |-> $past(en_live[3]))
        else $error("area 3 selected while disabled");
    a_full_space: assert property (cpu_cycle_i && cpu_addr_i >= FULL_SPACE_FIRST && en_live[2]
        && !ctl_q[2][CTRL_MODE_BIT] && !ctl_q[0][4] && !ctl_q[1][4] |=> cs_n == 4'b1011)
        else $error("area 2 missed a full-space address");
endmodule
bind cs_decode cs_decode_chk i_cs_decode_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .cpu_cycle_i(cpu_cycle_i), .cpu_addr_i(cpu_addr_i),
    .chip_select_0_n_o(chip_select_0_n_o), .chip_select_1_n_o(chip_select_1_n_o),
    .chip_select_2_n_o(chip_select_2_n_o), .chip_select_3_n_o(chip_select_3_n_o),
    .internal_io_o(internal_io_o), .cycle_attr_o(cycle_attr_o));
`default_nettype wire

// ---- dv/ext_devices.sv ----
/* model of the four external devices on the select lines.
   assumes active-low selects sampled on clk_i. */
`timescale 1ns/1ns
`default_nettype none
module ext_devices
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [3:0] cs_n_i,
    output logic      [3:0] seen_o,
    output logic            clash_o
);
    // records which devices were ever selected, and any bus contention
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            seen_o <= 4'h0;
            clash_o <= 1'b0;
        end
        else
        begin
            seen_o <= seen_o | ~cs_n_i;
            if ($countones(~cs_n_i) > 1)
                clash_o <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
/* self-checking bench: register access over classic wishbone and cpu cycles.
   assumes cs_decode, its checker and ext_devices are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import cs_decode_pkg::*;
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, cyc_cpu = 0, io, clash, ack;
    logic [10:0] adr = '0;
    logic [3:0]  sel = '0, seen;
    wire logic [3:0] cs_n;
    logic [31:0] wdat = '0, rdat;
    logic [23:0] cpu_addr = '0;
    cycle_attr_s attr;
    int          err_total = 0, check_count = 0;
    cs_decode i_cs_decode (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .cpu_cycle_i(cyc_cpu), .cpu_addr_i(cpu_addr), .chip_select_0_n_o(cs_n[0]),
        .chip_select_1_n_o(cs_n[1]), .chip_select_2_n_o(cs_n[2]), .chip_select_3_n_o(cs_n[3]),
        .internal_io_o(io), .cycle_attr_o(attr));
    ext_devices i_ext_devices (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .seen_o(seen), .clash_o(clash));
    initial forever #10 clk_i = ~clk_i;
////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrap_up;
        if (err_total == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic bus(input logic [8:0] idx, input logic w, input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge clk_i);
        {cyc, stb, we, sel} <= {1'b1, 1'b1, w, 4'h1};
        adr <= {idx, 2'b00};
        wdat <= {24'h0, d};
        n = 0;
        do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 20);
        q = rdat[7:0];
        {cyc, stb} <= 2'b00;
        if (ack !== 1'b1)
        begin
            err_total++;
            wrap_up();
        end
    endtask
    task automatic wr(input logic [8:0] idx, input logic [7:0] d);
        logic [7:0] q;
        bus(idx, 1'b1, d, q);
    endtask
    task automatic rd(input logic [8:0] idx, input logic [7:0] exp);
        logic [7:0] q;
        bus(idx, 1'b0, 8'h00, q);
        check("register", q, exp);
    endtask
    task automatic cpu(input logic [23:0] a, input logic [3:0] exp);
        @(posedge clk_i);
        cyc_cpu <= 1'b1;
        cpu_addr <= a;
        @(posedge clk_i);
        cyc_cpu <= 1'b0;
        @(negedge clk_i);
        check("selects", cs_n, exp);
    endtask
////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 8; i++)
            rd(9'(i < 4 ? 'h3c + i : 'h58 + i), 8'hff);
        rd(IDX_AREA2_CTRL, 8'h10);
        rd(IDX_AREA0_CTRL, 8'h00);
        rd(9'h000, 8'h00);
        cpu(24'h000080, 4'hb);
        check("io flag", io, 1'b0);
        cpu(24'hffffff, 4'hb);
        cpu(24'h00007f, 4'hf);
        check("io flag", io, 1);
        wr(IDX_AREA0_START, 8'h01);
        wr(IDX_AREA0_MASK, 8'h07);
        wr(IDX_AREA0_CTRL, 8'h13);
        cpu(24'h010000, 4'he);
        check("attributes", attr, 3'h3);
        cpu(24'h01ffff, 4'he);
        cpu(24'h020000, 4'hb);
        wr(IDX_AREA1_START, 8'h02);
        wr(IDX_AREA1_MASK, 8'h02);
        wr(IDX_AREA1_CTRL, 8'h10);
        cpu(24'h02fe00, 4'hd);
        cpu(24'h020100, 4'hb);
        wr(IDX_AREA0_MASK, 8'hff);
        cpu(24'h1f0000, 4'he);
        cpu(24'h200000, 4'hb);
        wr(IDX_AREA2_START, 8'h80);
        wr(IDX_AREA2_MASK, 8'h00);
        wr(IDX_AREA2_CTRL, 8'h18);
        cpu(24'h807fff, 4'hb);
        cpu(24'h808000, 4'hf);
        cpu(24'h400000, 4'hf);
        wr(IDX_AREA3_START, 8'h40);
        wr(IDX_AREA3_MASK, 8'hff);
        cpu(24'h400000, 4'hf);
        wr(IDX_AREA3_CTRL, 8'h10);
        cpu(24'h7fffff, 4'h7);
        rd(IDX_AREA3_START, 8'h40);
        wr(IDX_DEFAULT_CTRL, 8'h05);
        cpu(24'h000010, 4'hf);
        check("attributes", attr, 3'h5);
        check("devices seen", seen, 4'hf);
        check("contention", clash, 1'b0);
        wrap_up();
    end
endmodule
`default_nettype wire
